/* File: fsafe_pkg.sv */
// fsafe_pkg: register map, field positions, timing and carrier types
// assumes one 100 MHz clock shared by bus, frame logic and buffer
package fsafe_pkg;
    // ----------------------------------------------------------------
    // register map (byte addresses, one 32-bit word each)
    // ----------------------------------------------------------------
    localparam logic [7:0] MODE_OFFS = 8'h00;
    localparam logic [7:0] LINK_OFFS = 8'h04;
    localparam logic [7:0] ACC_OFFS = 8'h08;
    localparam logic [7:0] IST_OFFS = 8'h0C;
    localparam logic [7:0] IMASK_OFFS = 8'h10;
    localparam logic [7:0] STAT_OFFS = 8'h14;
    localparam logic [7:0] BADDR_OFFS = 8'h18;
    localparam logic [7:0] BDATA_OFFS = 8'h1C;
    // ----------------------------------------------------------------
    // fields
    // ----------------------------------------------------------------
    localparam int FS_EN_BIT = 5;
    localparam int IND_LEN_LSB = 8;
    localparam int FAST_BIT = 16;
    localparam int ACC_RUPN_BIT = 4;
    localparam int ACC_NVALID_BIT = 5;
    localparam int ACC_NCLR_BIT = 6;
    localparam int ACC_UCLR_BIT = 7;
    localparam int IRQ_WDOG = 0;
    localparam int IRQ_OUTX = 1;
    localparam int IRQ_CLRDONE = 2;
    localparam int IRQ_REJECT = 3;
    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [31:0] MODE_RST = 32'h0000_0000;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [3:0] IRQ_RST = 4'h0;
    // ----------------------------------------------------------------
    // timing: bit time of the link, clear duration in bit clocks
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int BIT_TIME_NS = 1000;
    localparam int HALF_BIT_CYC = (BIT_TIME_NS / 2 + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
    localparam logic [31:0] LINK_RST = 32'(HALF_BIT_CYC - 1);
    localparam int CLR_SETUP_FAST = 16;
    localparam int CLR_SETUP_SLOW = 20;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        K_DATA = 2'b00,
        K_READ = 2'b01,
        K_LEAVE = 2'b10,
        K_GCCLR = 2'b11
    } fsafe_kind_t;
    typedef struct packed {
        logic valid;
        fsafe_kind_t kind;
        logic [8:0] len;
    } fsafe_evt_t;
    typedef struct packed {
        logic valid;
        logic [7:0] addr;
        logic [7:0] data;
    } fsafe_wr_t;
endpackage

/* File: fsafe_obuf_mem.sv */
// fsafe_obuf_mem: output data buffer, one write and one read port
// assumes a single clock; read data appear one cycle after the address
module fsafe_obuf_mem #(
    parameter int AW = 8,
    parameter int DW = 8
) (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    if (AW < 1 || AW > 12) begin : g_chk
        $error("fsafe_obuf_mem: AW out of range");
    end

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

/* File: fsafe_half_div.sv */
// fsafe_half_div: half bit clock enable for the output clear timer
// assumes div holds the period minus one; restart realigns the phase
module fsafe_half_div #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic restart,
    input wire logic [W-1:0] div,
    output logic tick
);
    logic [W-1:0] cnt_reg;

    if (W < 2) begin : g_chk
        $error("fsafe_half_div: W too small");
    end

    always_ff @(posedge clk) begin
        if (rst || restart) begin
            cnt_reg <= '0;
        end else if (cnt_reg >= div) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + W'(1);
        end
    end

    assign tick = !restart && (cnt_reg >= div);
endmodule

/* File: fsafe_ctrl.sv */
// fsafe_ctrl: fail-safe output handling of the default access point
// assumes frame decode and buffer writes arrive on clk from the link side
//
// Functional notes
// - fail-safe handling only while mode bit 5 is one
// - access byte: value 0-3, reply valid 4, valid 5, cleared 6, user 7
// - user-cleared flag written by application only, never by hardware
// - read-back in fail-safe with user-cleared set answers zero bytes
// - fail-safe accepts empty data frames whatever length is configured
// - empty frame: watchdog and exchange interrupts, reply, set both flags
// - fail-safe never zeroes the output buffer
// - master leave or clear command in fail-safe sets both flags
// - fail-safe off: empty frames only if configured length is 0, zero buffer, cleared never set
// - clearing n bytes: 15+n to 20+1.5n fast, 20+0.5n slow bit clocks
module fsafe_ctrl #(
    parameter int BUF_AW = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire fsafe_pkg::fsafe_evt_t frame_evt,
    input wire fsafe_pkg::fsafe_wr_t rx_wr,
    output logic frame_accept,
    output logic frame_reject,
    output logic reply_input,
    output logic rb_valid,
    output logic rb_zero,
    output logic irq
);
    // ----------------------------------------------------------------
    // checks and helpers
    // ----------------------------------------------------------------
    if (BUF_AW < 1 || BUF_AW > 8) begin : g_chk
        $error("fsafe_ctrl: BUF_AW must be 1..8");
    end

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a[1:0] == 2'b00) && (a <= fsafe_pkg::BDATA_OFFS);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] s);
        merge = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                merge[i*8 +: 8] = d[i*8 +: 8];
            end
        end
    endfunction

    logic [31:0] mode_reg;
    logic [31:0] link_reg;
    logic [7:0] acc_reg;
    logic [3:0] ist_reg;
    logic [3:0] imask_reg;
    logic [7:0] baddr_reg;
    logic [8:0] last_len_reg;
    logic fs_en;
    logic [8:0] ind_len;
    logic [31:0] wmerged;

    assign fs_en = mode_reg[fsafe_pkg::FS_EN_BIT];
    assign ind_len = mode_reg[fsafe_pkg::IND_LEN_LSB +: 9];

    // ----------------------------------------------------------------
    // bus write channel
    // ----------------------------------------------------------------
    logic aw_hold_reg;
    logic w_hold_reg;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic wr_do;
    logic wr_acc;

    assign s_axi_awready = !aw_hold_reg;
    assign s_axi_wready = !w_hold_reg;
    assign wr_do = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
    assign wr_acc = wr_do && (awaddr_reg == fsafe_pkg::ACC_OFFS)
                    && wstrb_reg[0];

    always_ff @(posedge clk) begin
        if (rst) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= fsafe_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_hold_reg) begin
                aw_hold_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_hold_reg) begin
                w_hold_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (wr_do) begin
                aw_hold_reg <= 1'b0;
                w_hold_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= addr_ok(awaddr_reg) ? fsafe_pkg::RESP_OKAY
                                                   : fsafe_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // software written registers
    // ----------------------------------------------------------------
    always_comb begin
        wmerged = 32'h0000_0000;
        case (awaddr_reg)
            fsafe_pkg::MODE_OFFS: wmerged = merge(mode_reg, wdata_reg,
                                                  wstrb_reg);
            fsafe_pkg::LINK_OFFS: wmerged = merge(link_reg, wdata_reg,
                                                  wstrb_reg);
            fsafe_pkg::IMASK_OFFS: wmerged = merge({28'h0, imask_reg},
                                                   wdata_reg, wstrb_reg);
            fsafe_pkg::BADDR_OFFS: wmerged = merge({24'h0, baddr_reg},
                                                   wdata_reg, wstrb_reg);
            default: wmerged = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mode_reg <= fsafe_pkg::MODE_RST;
            link_reg <= fsafe_pkg::LINK_RST;
            imask_reg <= fsafe_pkg::IRQ_RST;
            baddr_reg <= 8'h00;
        end else if (wr_do) begin
            case (awaddr_reg)
                fsafe_pkg::MODE_OFFS: mode_reg <= wmerged;
                fsafe_pkg::LINK_OFFS: link_reg <= wmerged;
                fsafe_pkg::IMASK_OFFS: imask_reg <= wmerged[3:0];
                fsafe_pkg::BADDR_OFFS: baddr_reg <= wmerged[7:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // frame decode
    // ----------------------------------------------------------------
    logic is_data;
    logic is_read;
    logic is_leave;
    logic empty_ok;
    logic data_acc;
    logic data_rej;
    logic set_both;
    logic clr_busy_reg;
    logic clr_start;
    logic clr_done;

    assign is_data = frame_evt.valid && frame_evt.kind == fsafe_pkg::K_DATA;
    assign is_read = frame_evt.valid && frame_evt.kind == fsafe_pkg::K_READ;
    assign is_leave = frame_evt.valid
                      && (frame_evt.kind == fsafe_pkg::K_LEAVE
                          || frame_evt.kind == fsafe_pkg::K_GCCLR);
    // empty frames only recognised with fail-safe on
    assign empty_ok = fs_en && frame_evt.len == 9'h000;
    assign data_acc = is_data && (empty_ok || frame_evt.len == ind_len);
    assign data_rej = is_data && !data_acc;
    assign set_both = fs_en && ((data_acc && frame_evt.len == 9'h000)
                                || is_leave);
    // a clear already running absorbs a second request
    assign clr_start = is_leave && !fs_en && !clr_busy_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            frame_accept <= 1'b0;
            frame_reject <= 1'b0;
            reply_input <= 1'b0;
            rb_valid <= 1'b0;
            rb_zero <= 1'b0;
            last_len_reg <= 9'h000;
        end else begin
            frame_accept <= data_acc;
            frame_reject <= data_rej;
            reply_input <= data_acc;
            rb_valid <= is_read;
            if (is_read) begin
                rb_zero <= fs_en && acc_reg[fsafe_pkg::ACC_UCLR_BIT];
            end
            if (data_acc) begin
                last_len_reg <= frame_evt.len;
            end
        end
    end

    // ----------------------------------------------------------------
    // access byte: hardware sets win over software clears
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            acc_reg <= fsafe_pkg::ACC_RST;
        end else begin
            if (wr_acc) begin
                acc_reg[fsafe_pkg::ACC_RUPN_BIT:0] <=
                    wdata_reg[fsafe_pkg::ACC_RUPN_BIT:0];
                acc_reg[fsafe_pkg::ACC_UCLR_BIT] <=
                    wdata_reg[fsafe_pkg::ACC_UCLR_BIT];
                if (wdata_reg[fsafe_pkg::ACC_NVALID_BIT]) begin
                    acc_reg[fsafe_pkg::ACC_NVALID_BIT] <= 1'b0;
                end
                if (wdata_reg[fsafe_pkg::ACC_NCLR_BIT]) begin
                    acc_reg[fsafe_pkg::ACC_NCLR_BIT] <= 1'b0;
                end
            end
            if (data_acc || set_both) begin
                acc_reg[fsafe_pkg::ACC_NVALID_BIT] <= 1'b1;
            end
            if (set_both) begin
                acc_reg[fsafe_pkg::ACC_NCLR_BIT] <= 1'b1;
            end else if (data_acc) begin
                acc_reg[fsafe_pkg::ACC_NCLR_BIT] <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // output clear engine, timed in half bit clocks
    // ----------------------------------------------------------------
    logic half_tick;
    logic [9:0] clr_half_reg;
    logic [9:0] clr_target_reg;
    logic [8:0] clr_addr_reg;
    logic [8:0] clr_len_reg;
    logic clr_wr;
    logic fast;

    assign fast = link_reg[fsafe_pkg::FAST_BIT];
    assign clr_wr = clr_busy_reg && clr_addr_reg < clr_len_reg;
    assign clr_done = clr_busy_reg && !clr_wr
                      && clr_half_reg >= clr_target_reg;

    fsafe_half_div #(
        .W(16)
    ) u_div (
        .clk(clk),
        .rst(rst),
        .restart(clr_start),
        .div(link_reg[15:0]),
        .tick(half_tick)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            clr_busy_reg <= 1'b0;
            clr_half_reg <= 10'h000;
            clr_target_reg <= 10'h000;
            clr_addr_reg <= 9'h000;
            clr_len_reg <= 9'h000;
        end else if (clr_start) begin
            clr_busy_reg <= 1'b1;
            clr_half_reg <= 10'h000;
            clr_addr_reg <= 9'h000;
            clr_len_reg <= ind_len;
            // fast: 2*(16+n) halves; slow: 2*20+n halves
            if (fast) begin
                clr_target_reg <= 10'(2 * fsafe_pkg::CLR_SETUP_FAST)
                                  + {ind_len, 1'b0};
            end else begin
                clr_target_reg <= 10'(2 * fsafe_pkg::CLR_SETUP_SLOW)
                                  + {1'b0, ind_len};
            end
        end else if (clr_busy_reg) begin
            if (clr_wr) begin
                clr_addr_reg <= clr_addr_reg + 9'h001;
            end
            if (half_tick && clr_half_reg < clr_target_reg) begin
                clr_half_reg <= clr_half_reg + 10'h001;
            end
            if (clr_done) begin
                clr_busy_reg <= 1'b0;
            end
        end
    end

    logic [7:0] mem_q;

    // clear engine owns the write port while bytes remain to clear; frame bytes then lost
    fsafe_obuf_mem #(
        .AW(BUF_AW),
        .DW(8)
    ) u_mem (
        .clk(clk),
        .wr_en(clr_wr || rx_wr.valid),
        .wr_addr(clr_wr ? clr_addr_reg[BUF_AW-1:0]
                        : rx_wr.addr[BUF_AW-1:0]),
        .wr_data(clr_wr ? 8'h00 : rx_wr.data),
        .rd_addr(baddr_reg[BUF_AW-1:0]),
        .rd_data(mem_q)
    );

    // ----------------------------------------------------------------
    // interrupts: read of status clears, new event wins
    // ----------------------------------------------------------------
    logic ar_hs;
    logic ist_rd;
    logic [3:0] ist_set;

    assign ar_hs = s_axi_arvalid && s_axi_arready;
    assign ist_rd = ar_hs && s_axi_araddr == fsafe_pkg::IST_OFFS;
    always_comb begin
        ist_set = 4'h0;
        ist_set[fsafe_pkg::IRQ_WDOG] = data_acc;
        ist_set[fsafe_pkg::IRQ_OUTX] = data_acc;
        ist_set[fsafe_pkg::IRQ_CLRDONE] = clr_done;
        ist_set[fsafe_pkg::IRQ_REJECT] = data_rej;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ist_reg <= fsafe_pkg::IRQ_RST;
        end else begin
            ist_reg <= (ist_rd ? 4'h0 : ist_reg) | ist_set;
        end
    end

    assign irq = |(ist_reg & imask_reg);

    // ----------------------------------------------------------------
    // bus read channel; buffer data take one extra cycle
    // ----------------------------------------------------------------
    logic rd_wait_reg;
    logic [31:0] rd_mux;

    assign s_axi_arready = !s_axi_rvalid && !rd_wait_reg;

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (s_axi_araddr)
            fsafe_pkg::MODE_OFFS: rd_mux = mode_reg;
            fsafe_pkg::LINK_OFFS: rd_mux = link_reg;
            fsafe_pkg::ACC_OFFS: rd_mux = {24'h0, acc_reg};
            fsafe_pkg::IST_OFFS: rd_mux = {28'h0, ist_reg};
            fsafe_pkg::IMASK_OFFS: rd_mux = {28'h0, imask_reg};
            fsafe_pkg::STAT_OFFS: rd_mux = {15'h0, last_len_reg,
                                            7'h0, clr_busy_reg};
            fsafe_pkg::BADDR_OFFS: rd_mux = {24'h0, baddr_reg};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_wait_reg <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= fsafe_pkg::RESP_OKAY;
        end else if (ar_hs) begin
            s_axi_rresp <= addr_ok(s_axi_araddr) ? fsafe_pkg::RESP_OKAY
                                                 : fsafe_pkg::RESP_SLVERR;
            if (s_axi_araddr == fsafe_pkg::BDATA_OFFS) begin
                rd_wait_reg <= 1'b1;
            end else begin
                s_axi_rdata <= rd_mux;
                s_axi_rvalid <= 1'b1;
            end
        end else if (rd_wait_reg) begin
            rd_wait_reg <= 1'b0;
            s_axi_rdata <= {24'h0, mem_q};
            s_axi_rvalid <= 1'b1;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_empty_frame;
        is_data && fs_en && frame_evt.len == 9'h000;
    endsequence
    sequence s_flags_both;
        acc_reg[5] && acc_reg[6] && ist_reg[0] && ist_reg[1] && reply_input;
    endsequence

    chk_empty_flags: assert property (
        s_empty_frame |=> s_flags_both)
        else $error("empty frame did not set flags");
    chk_empty_accept: assert property (
        s_empty_frame |=> frame_accept && !frame_reject)
        else $error("empty frame not accepted");
    chk_mode_gate: assert property (
        is_data && !fs_en && frame_evt.len == 9'h000 && ind_len != 9'h000
        |=> frame_reject && !frame_accept)
        else $error("empty frame taken with fail-safe off");
    chk_nonzero_flags: assert property (
        data_acc && fs_en && frame_evt.len != 9'h000
        |=> acc_reg[5] && !acc_reg[6])
        else $error("data frame flags wrong");
    chk_user_flag: assert property (
        !wr_acc |=> $stable(acc_reg[7]))
        else $error("hardware changed user-cleared flag");
    chk_readback_zero: assert property (
        is_read |=> rb_valid && rb_zero == $past(fs_en && acc_reg[7]))
        else $error("read-back zero answer wrong");
    chk_no_clear_fs: assert property (
        fs_en && !clr_busy_reg |=> !clr_busy_reg)
        else $error("buffer clear started in fail-safe");
    chk_leave_flags: assert property (
        is_leave && fs_en |=> acc_reg[5] && acc_reg[6])
        else $error("leave did not set flags");
    chk_off_clear: assert property (
        is_leave && !fs_en && !clr_busy_reg
        |=> clr_busy_reg && clr_addr_reg == 9'h000)
        else $error("clear not started with fail-safe off");
    chk_off_no_cleared: assert property (
        !fs_en && !acc_reg[6] |=> !acc_reg[6])
        else $error("cleared flag set with fail-safe off");
    chk_clear_time: assert property (
        clr_done |-> (fast
        ? (int'(clr_half_reg) > 30 + 2 * int'(clr_len_reg)
           && int'(clr_half_reg) < 40 + 3 * int'(clr_len_reg))
        : int'(clr_half_reg) == 40 + int'(clr_len_reg))
        && clr_addr_reg == clr_len_reg)
        else $error("clear time out of range");
endmodule

/* File: fsafe_dpm.sv */
// fsafe_dpm: fieldbus master stand-in, frame events and output bytes
// assumes calls start just after a rising clk edge
module fsafe_dpm (
    input wire logic clk,
    output fsafe_pkg::fsafe_evt_t frame_evt,
    output fsafe_pkg::fsafe_wr_t rx_wr
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        frame_evt = '0;
        rx_wr = '0;
    end
    // one-cycle pulses; a frame event is any kind, any length
    task automatic evt(input logic [1:0] k, input logic [8:0] n);
        frame_evt <= {1'b1, fsafe_pkg::fsafe_kind_t'(k), n};
        @(posedge clk);
        frame_evt <= '0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        rx_wr <= {1'b1, a, d};
        @(posedge clk);
        rx_wr <= '0;
    endtask
endmodule

/* File: fsafe_tb.sv */
// testbench: register and frame sequences for fsafe_ctrl
// assumes fsafe_pkg, fsafe_ctrl and fsafe_dpm compiled first
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, awv, wv, arv, awr, wrd, bv, arr, rv;
    logic acc, rej, rep, rbv, rbz, irq;
    logic [7:0] awa, ara;
    logic [31:0] wd, rd;
    logic [1:0] rr, br;
    fsafe_pkg::fsafe_evt_t ev;
    fsafe_pkg::fsafe_wr_t rw;
    int n_errors = 0;
    int tests_run = 0;
    int c;
    fsafe_ctrl dut_u (.clk(clk), .rst(rst), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(1'b1),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
        .s_axi_rready(1'b1), .frame_evt(ev), .rx_wr(rw),
        .frame_accept(acc), .frame_reject(rej), .reply_input(rep),
        .rb_valid(rbv), .rb_zero(rbz), .irq(irq));
    fsafe_dpm dpm_u (.clk(clk), .frame_evt(ev), .rx_wr(rw));
    // ----------------------------------------
    // bus tasks: handshakes sampled at the rising edge
    // ----------------------------------------
    task automatic bw(input logic [7:0] a, input logic [31:0] d);
        logic hb;
        logic [1:0] g;
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        hb = 1'b0;
        g = 2'h0;
        while (!hb) begin
            @(posedge clk);
            if (awr && awv) awv <= 1'b0;
            if (wrd && wv) wv <= 1'b0;
            hb = bv;
            g = br;
        end
        chk(g, (a > fsafe_pkg::BDATA_OFFS) ? fsafe_pkg::RESP_SLVERR
                                         : fsafe_pkg::RESP_OKAY);
    endtask
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        logic hb;
        logic [1:0] er;
        logic [33:0] g;
        ara <= a;
        arv <= 1'b1;
        hb = 1'b0;
        g = '0;
        while (!hb) begin
            @(posedge clk);
            if (arr && arv) arv <= 1'b0;
            hb = rv;
            g = {rr, rd};
        end
        er = (a > fsafe_pkg::BDATA_OFFS) ? fsafe_pkg::RESP_SLVERR
                                         : fsafe_pkg::RESP_OKAY;
        chk(g, {er, e});
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // slow clear alone is about 2200 cycles
    initial begin
        #100000;
        n_errors++;
        results();
    end
    initial begin
        {rst, awv, wv, arv, awa, ara, wd} = {4'b1000, 48'h0};
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rc(fsafe_pkg::MODE_OFFS, fsafe_pkg::MODE_RST);
        rc(fsafe_pkg::ACC_OFFS, 32'h0);
        rc(8'h20, 32'h0);
        bw(8'h24, 32'hFFFF_FFFF);
        $display("reset values done");
        bw(fsafe_pkg::MODE_OFFS, 32'h0000_0420);
        bw(fsafe_pkg::IMASK_OFFS, 32'h3);
        dpm_u.evt(2'h0, 9'h0);
        @(posedge clk) chk({acc, rep}, 2'b11);
        chk(irq, 1'b1);
        rc(fsafe_pkg::ACC_OFFS, 32'h60);
        rc(fsafe_pkg::IST_OFFS, 32'h3);
        rc(fsafe_pkg::IST_OFFS, 32'h0);
        $display("empty frame done");
        bw(fsafe_pkg::ACC_OFFS, 32'hE5);
        rc(fsafe_pkg::ACC_OFFS, 32'h85);
        dpm_u.evt(2'h1, 9'h0);
        @(posedge clk) chk({rbv, rbz}, 2'b11);
        dpm_u.wr(8'h02, 8'hA5);
        dpm_u.evt(2'h0, 9'h4);
        rc(fsafe_pkg::ACC_OFFS, 32'hA5);
        for (int k = 2; k < 4; k++) begin
            bw(fsafe_pkg::ACC_OFFS, 32'hE0);
            dpm_u.evt(k[1:0], 9'h0);
            rc(fsafe_pkg::ACC_OFFS, 32'hE0);
        end
        bw(fsafe_pkg::BADDR_OFFS, 32'h2);
        rc(fsafe_pkg::BDATA_OFFS, 32'hA5);
        $display("fail-safe on done");
        bw(fsafe_pkg::MODE_OFFS, 32'h0000_0400);
        bw(fsafe_pkg::IMASK_OFFS, 32'hC);
        bw(fsafe_pkg::ACC_OFFS, 32'hE0);
        dpm_u.evt(2'h0, 9'h0);
        @(posedge clk) chk({acc, rej}, 2'b01);
        rc(fsafe_pkg::IST_OFFS, 32'hB);
        dpm_u.evt(2'h3, 9'h0);
        c = 0;
        while (irq !== 1'b1 && c < 5000) begin
            @(negedge clk);
            c++;
        end
        // 20+0.5n bit clocks, n=4, 100 cycles a bit
        chk(c > 2100 && c < 2300, 1);
        @(posedge clk);
        rc(fsafe_pkg::BDATA_OFFS, 32'h0);
        rc(fsafe_pkg::ACC_OFFS, 32'h80);
        dpm_u.evt(2'h1, 9'h0);
        @(posedge clk) chk({rbv, rbz}, 2'b10);
        rc(fsafe_pkg::IST_OFFS, 32'h4);
        bw(fsafe_pkg::LINK_OFFS, 32'h0001_0001);
        dpm_u.evt(2'h2, 9'h0);
        c = 0;
        while (irq !== 1'b1 && c < 500) begin
            @(negedge clk);
            c++;
        end
        // fast: 15+n to 20+1.5n bit clocks, 4 cycles a bit
        chk(c > 76 && c < 104, 1);
        @(posedge clk);
        $display("fail-safe off done");
        results();
    end
endmodule
